// >>> vrp_pkg.sv
package vrp_pkg;
    // ---------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------
    localparam logic [4:0] VRP_OFS_CTRL    = 5'h00;
    localparam logic [4:0] VRP_OFS_LCORR   = 5'h04;
    localparam logic [4:0] VRP_OFS_LDIST   = 5'h08;
    localparam logic [4:0] VRP_OFS_ADDR    = 5'h0C;
    localparam logic [4:0] VRP_OFS_DIAG    = 5'h10;
    localparam logic [4:0] VRP_OFS_IRQ_ST  = 5'h14;
    localparam logic [4:0] VRP_OFS_IRQ_MSK = 5'h18;
    localparam logic [4:0] VRP_OFS_LAST    = 5'h1C;
    // ---------------------------------------------
    // Control field positions
    // ---------------------------------------------
    localparam int VRP_CTRL_DIR_EN   = 0;
    localparam int VRP_CTRL_WW_EN    = 1;
    localparam int VRP_CTRL_NORM_DIR = 2;
    localparam int VRP_CTRL_LTYPE    = 3;
    localparam int VRP_CTRL_HWA_EN   = 4;
    localparam int VRP_CTRL_DEFLOAD  = 5;
    localparam logic [4:0] VRP_CTRL_RST = 5'h13;
    // ---------------------------------------------
    // Interrupt bits
    // ---------------------------------------------
    localparam int VRP_IRQ_VEH  = 0;
    localparam int VRP_IRQ_WW   = 1;
    localparam int VRP_IRQ_FREQ = 2;
    localparam int VRP_IRQ_W    = 3;
    // ---------------------------------------------
    // Values in decimetres, except VRP_ADDR_RST, which is a bus address
    // ---------------------------------------------
    localparam logic [4:0] VRP_LCORR_MAX   = 5'h14;
    localparam logic [4:0] VRP_LCORR_STD   = 5'h0A;
    localparam logic [4:0] VRP_LCORR_VAR   = 5'h0A;
    localparam logic [7:0] VRP_LLEN_STD    = 8'h14;
    localparam logic [7:0] VRP_LLEN_VAR    = 8'h14;
    localparam logic [7:0] VRP_LDIST_STD   = 8'h28;
    localparam logic [7:0] VRP_LDIST_MIN   = 8'h1E;
    localparam logic [7:0] VRP_LDIST_MAX   = 8'h64;
    localparam logic [7:0] VRP_ADDR_RST    = 8'h01;
    // ---------------------------------------------
    // LED blink timing
    // ---------------------------------------------
    localparam int VRP_CLK_MHZ       = 250;
    localparam int VRP_BLINK_HALF_MS = 250;
    localparam int VRP_BLINK_HALF_CYC = VRP_BLINK_HALF_MS * 1000 * VRP_CLK_MHZ;
    localparam logic [2:0] VRP_BLINK_CNT = 3'h3;
    typedef enum logic [1:0] {
        VRP_LED_IDLE = 2'b00,
        VRP_LED_ON   = 2'b01,
        VRP_LED_OFF  = 2'b10
    } vrp_led_t;
endpackage : vrp_pkg

// >>> vrp_record.sv
`timescale 1ns/10ps
module vrp_record
    import vrp_pkg::*;
#(
    parameter int LW = 10
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          veh_valid,
    input  wire logic [LW-1:0] veh_atten_len,
    input  wire logic          veh_dir,
    input  wire logic [4:0]    len_corr,
    input  wire logic          dir_en,
    input  wire logic          ww_en,
    input  wire logic          norm_dir,
    output logic               tel_valid,
    output logic [LW-1:0]      tel_length,
    output logic               tel_wrong_way,
    output logic               svc_ww_prefix,
    output logic               svc_dir_digit
);
    wire [LW-1:0] corr_w = LW'(len_corr);
    wire [LW-1:0] len_w  = (veh_atten_len > corr_w) ? veh_atten_len - corr_w : '0;
    wire          opp_w  = veh_dir ^ norm_dir;
    wire          ww_w   = dir_en & ww_en & opp_w;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tel_valid     <= 1'b0;
            tel_length    <= '0;
            tel_wrong_way <= 1'b0;
            svc_ww_prefix <= 1'b0;
            svc_dir_digit <= 1'b0;
        end else begin
            tel_valid <= veh_valid;
            if (veh_valid) begin
                tel_length    <= len_w;
                tel_wrong_way <= ww_w;
                svc_ww_prefix <= ww_w;
                svc_dir_digit <= veh_dir;
            end
        end
    end
endmodule : vrp_record

// >>> vrp_blink.sv
`timescale 1ns/10ps
module vrp_blink
    import vrp_pkg::*;
#(
    parameter int HALF_CYC = VRP_BLINK_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      led
);
    // Divider gives one tick per half blink period
    logic [31:0] div_r;
    logic [2:0]  cnt_r;
    vrp_led_t    st_r;
    wire         tick_w = (div_r == 32'(HALF_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (st_r == VRP_LED_IDLE || tick_w) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r  <= VRP_LED_IDLE;
            cnt_r <= '0;
        end else begin
            case (st_r)
                VRP_LED_IDLE: begin
                    if (start) begin
                        st_r  <= VRP_LED_ON;
                        cnt_r <= VRP_BLINK_CNT;
                    end
                end
                VRP_LED_ON: begin
                    if (tick_w) begin
                        st_r  <= VRP_LED_OFF;
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                VRP_LED_OFF: begin
                    if (tick_w) begin
                        st_r <= (cnt_r == 3'h0) ? VRP_LED_IDLE : VRP_LED_ON;
                    end
                end
                default: st_r <= VRP_LED_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led <= 1'b0;
        end else begin
            led <= (st_r == VRP_LED_ON);
        end
    end
endmodule : vrp_blink

// >>> vrp_top.sv
`timescale 1ns/10ps
module vrp_top
    import vrp_pkg::*;
#(
    parameter int LW       = 10,
    parameter int HALF_CYC = VRP_BLINK_HALF_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [4:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          veh_valid,
    input  wire logic [LW-1:0] veh_atten_len,
    input  wire logic          veh_dir,
    input  wire logic          hw_addr_wired,
    input  wire logic [7:0]    hw_addr_in,
    input  wire logic          freq_unreach,
    output logic               tel_valid,
    output logic [LW-1:0]      tel_length,
    output logic               tel_wrong_way,
    output logic               svc_ww_prefix,
    output logic               svc_dir_digit,
    output logic [7:0]         bus_addr,
    output logic [7:0]         loop_dist,
    output logic               pattern_set,
    output logic               err_led,
    output logic               chan_led,
    output logic               irq
);
    import vrp_pkg::*;

    // ---------------------------------------------
    // Register state
    // ---------------------------------------------
    logic [4:0]          ctrl_r;
    logic [4:0]          lcorr_r;
    logic [7:0]          ldist_r;
    logic [7:0]          addr_r;
    logic [VRP_IRQ_W-1:0] ist_r;
    logic [VRP_IRQ_W-1:0] imsk_r;
    logic                ack_r;
    logic [31:0]         rdata_r;
    logic                fault_r;

    // ---------------------------------------------
    // Bus decode
    // ---------------------------------------------
    // One wait state: read data are fetched in the first cycle and stand in the second
    wire req_w    = avs_read | avs_write;
    wire wr_w     = avs_write & ack_r;
    wire be0_w    = avs_byteenable[0];
    wire sel_ctrl = (avs_address == VRP_OFS_CTRL);
    wire sel_lc   = (avs_address == VRP_OFS_LCORR);
    wire sel_ld   = (avs_address == VRP_OFS_LDIST);
    wire sel_ad   = (avs_address == VRP_OFS_ADDR);
    wire sel_diag = (avs_address == VRP_OFS_DIAG);
    wire sel_ist  = (avs_address == VRP_OFS_IRQ_ST);
    wire sel_imsk = (avs_address == VRP_OFS_IRQ_MSK);
    wire sel_last = (avs_address == VRP_OFS_LAST);
    wire [7:0] wd_w = avs_writedata[7:0];

    assign avs_waitrequest = req_w & ~ack_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_w & ~ack_r;
        end
    end

    // ---------------------------------------------
    // Configuration derived values
    // ---------------------------------------------
    wire ltype_w   = ctrl_r[VRP_CTRL_LTYPE];
    wire [4:0] lc_def_w = wd_w[VRP_CTRL_LTYPE] ? VRP_LCORR_VAR : VRP_LCORR_STD;
    wire [4:0] lc_wr_w  = (wd_w > 8'(VRP_LCORR_MAX)) ? VRP_LCORR_MAX : wd_w[4:0];
    wire [7:0] ld_clamp_w = (ldist_r < VRP_LDIST_MIN) ? VRP_LDIST_MIN :
                            (ldist_r > VRP_LDIST_MAX) ? VRP_LDIST_MAX : ldist_r;
    wire [7:0] llen_w  = ltype_w ? VRP_LLEN_VAR : VRP_LLEN_STD;
    wire hwa_use_w     = hw_addr_wired & ctrl_r[VRP_CTRL_HWA_EN];
    wire [7:0] addr_w  = hwa_use_w ? hw_addr_in : addr_r;
    wire deflt_w       = wr_w & sel_ctrl & be0_w & wd_w[VRP_CTRL_DEFLOAD];

    wire [7:0] ldist_eff_w = ltype_w ? ld_clamp_w : VRP_LDIST_STD;

    // ---------------------------------------------
    // Output registers
    // ---------------------------------------------
    // Registered so pin-side logic never sees decode glitches; costs one cycle of latency
    logic [7:0] bus_addr_r;
    logic [7:0] loop_dist_r;
    logic       pattern_set_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_addr_r <= VRP_ADDR_RST;
        end else begin
            bus_addr_r <= addr_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_dist_r <= VRP_LDIST_STD;
        end else begin
            loop_dist_r <= ldist_eff_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pattern_set_r <= 1'b0;
        end else begin
            pattern_set_r <= ltype_w;
        end
    end

    assign loop_dist   = loop_dist_r;
    assign bus_addr    = bus_addr_r;
    assign pattern_set = pattern_set_r;

    // ---------------------------------------------
    // Writable registers
    // ---------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= VRP_CTRL_RST;
        end else if (wr_w && sel_ctrl && be0_w) begin
            ctrl_r <= wd_w[4:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lcorr_r <= VRP_LCORR_STD;
        end else if (deflt_w) begin
            lcorr_r <= lc_def_w;
        end else if (wr_w && sel_lc && be0_w) begin
            lcorr_r <= lc_wr_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ldist_r <= VRP_LDIST_STD;
        end else if (wr_w && sel_ld && be0_w) begin
            ldist_r <= wd_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= VRP_ADDR_RST;
        end else if (wr_w && sel_ad && be0_w) begin
            addr_r <= wd_w;
        end
    end

    // ---------------------------------------------
    // Record processing
    // ---------------------------------------------
    vrp_record #(
        .LW (LW)
    ) u_rec (
        .clk           (clk),
        .rst_n         (rst_n),
        .veh_valid     (veh_valid),
        .veh_atten_len (veh_atten_len),
        .veh_dir       (veh_dir),
        .len_corr      (lcorr_r),
        .dir_en        (ctrl_r[VRP_CTRL_DIR_EN]),
        .ww_en         (ctrl_r[VRP_CTRL_WW_EN]),
        .norm_dir      (ctrl_r[VRP_CTRL_NORM_DIR]),
        .tel_valid     (tel_valid),
        .tel_length    (tel_length),
        .tel_wrong_way (tel_wrong_way),
        .svc_ww_prefix (svc_ww_prefix),
        .svc_dir_digit (svc_dir_digit)
    );

    // ---------------------------------------------
    // Frequency fault and LEDs
    // ---------------------------------------------
    vrp_blink #(
        .HALF_CYC (HALF_CYC)
    ) u_blink (
        .clk   (clk),
        .rst_n (rst_n),
        .start (freq_unreach),
        .led   (chan_led)
    );

    // Fault stays lit until software clears its status bit; a new fault wins
    wire fclr_w = wr_w & sel_ist & be0_w & wd_w[VRP_IRQ_FREQ];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r <= 1'b0;
        end else if (freq_unreach) begin
            fault_r <= 1'b1;
        end else if (fclr_w) begin
            fault_r <= 1'b0;
        end
    end

    assign err_led = fault_r;

    // ---------------------------------------------
    // Interrupts
    // ---------------------------------------------
    wire [VRP_IRQ_W-1:0] iev_w = {freq_unreach, tel_valid & tel_wrong_way, tel_valid};
    wire [VRP_IRQ_W-1:0] iclr_w = (wr_w && sel_ist && be0_w) ? wd_w[VRP_IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_r <= '0;
        end else begin
            ist_r <= (ist_r & ~iclr_w) | iev_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            imsk_r <= '0;
        end else if (wr_w && sel_imsk && be0_w) begin
            imsk_r <= wd_w[VRP_IRQ_W-1:0];
        end
    end

    assign irq = |(ist_r & imsk_r);

    // ---------------------------------------------
    // Read data
    // ---------------------------------------------
    // Diagnostic word: pattern set, loop length, effective address, effective distance (clamped if pattern set, else standard)
    wire [31:0] diag_w = {7'h00, ltype_w, llen_w, addr_w, ldist_eff_w};
    wire [31:0] last_w = {{(30-LW){1'b0}}, svc_ww_prefix, svc_dir_digit, tel_length};
    wire [31:0] rmux_w = sel_ctrl ? {27'h0, ctrl_r} :
                         sel_lc   ? {27'h0, lcorr_r} :
                         sel_ld   ? {24'h0, ldist_r} :
                         sel_ad   ? {24'h0, addr_r} :
                         sel_diag ? diag_w :
                         sel_ist  ? {29'h0, ist_r} :
                         sel_imsk ? {29'h0, imsk_r} :
                         sel_last ? last_w : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0;
        end else if (avs_read && !ack_r) begin
            rdata_r <= rmux_w;
        end
    end

    assign avs_readdata = rdata_r;

    wire unused_w = ^{avs_writedata[31:8], avs_byteenable[3:1]};
endmodule : vrp_top

// >>> vrp_top_sva.sv
`timescale 1ns/10ps
module vrp_top_sva
    import vrp_pkg::*;
#(
    parameter int LW       = 10,
    parameter int HALF_CYC = 4
) (
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic [4:0]    avs_address,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic          avs_waitrequest,
    input wire logic          veh_valid,
    input wire logic [LW-1:0] veh_atten_len,
    input wire logic          veh_dir,
    input wire logic          freq_unreach,
    input wire logic          tel_valid,
    input wire logic [LW-1:0] tel_length,
    input wire logic          tel_wrong_way,
    input wire logic          svc_ww_prefix,
    input wire logic          svc_dir_digit,
    input wire logic [7:0]    loop_dist,
    input wire logic          err_led
);
    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_tel;
        veh_valid |=> tel_valid && svc_dir_digit == $past(veh_dir);
    endproperty
    a_tel: assert property (p_tel) else $error("telegram missing or wrong digit");
    property p_pulse;
        tel_valid |-> $past(veh_valid);
    endproperty
    a_pulse: assert property (p_pulse) else $error("telegram without vehicle");
    property p_prefix;
        tel_valid |-> svc_ww_prefix == tel_wrong_way;
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix disagrees with flag");
    // Correction never exceeds 20 dm, so the drop is bounded both ways
    property p_len;
        veh_valid |=> int'(tel_length) <= int'($past(veh_atten_len))
            && int'(tel_length) + 20 >= int'($past(veh_atten_len));
    endproperty
    a_len: assert property (p_len) else $error("length out of bounds");
    property p_dist;
        loop_dist >= VRP_LDIST_MIN && loop_dist <= VRP_LDIST_MAX;
    endproperty
    a_dist: assert property (p_dist) else $error("loop distance not clamped");
    property p_fault;
        freq_unreach |=> err_led;
    endproperty
    a_fault: assert property (p_fault) else $error("error led not lit");
    property p_errhold;
        err_led && !avs_write |=> err_led;
    endproperty
    a_errhold: assert property (p_errhold) else $error("error led dropped");
    property p_wait;
        (avs_read || avs_write) && !$past(avs_read || avs_write)
            |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
endmodule : vrp_top_sva

bind vrp_top vrp_top_sva #(.LW(LW), .HALF_CYC(HALF_CYC)) u_sva (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .veh_valid(veh_valid),
    .veh_atten_len(veh_atten_len), .veh_dir(veh_dir), .freq_unreach(freq_unreach),
    .tel_valid(tel_valid), .tel_length(tel_length), .tel_wrong_way(tel_wrong_way),
    .svc_ww_prefix(svc_ww_prefix), .svc_dir_digit(svc_dir_digit),
    .loop_dist(loop_dist), .err_led(err_led));

// >>> vrp_veh_src.sv
`timescale 1ns/10ps
module vrp_veh_src (
    input wire logic  clk,
    output logic       veh_valid,
    output logic [9:0] veh_atten_len,
    output logic       veh_dir,
    output logic       freq_unreach
);
    // Fields are scrambled when idle so nothing leans on stale values
    initial begin
        veh_valid = 1'b0;
        veh_atten_len = 10'h155;
        veh_dir = 1'b0;
        freq_unreach = 1'b0;
    end
    task send(input logic [9:0] len, input logic dir);
        @(posedge clk);
        veh_valid <= 1'b1;
        veh_atten_len <= len;
        veh_dir <= dir;
        @(posedge clk);
        veh_valid <= 1'b0;
        veh_atten_len <= ~len;
        veh_dir <= ~dir;
    endtask : send
    task fault();
        @(posedge clk);
        freq_unreach <= 1'b1;
        @(posedge clk);
        freq_unreach <= 1'b0;
    endtask : fault
endmodule : vrp_veh_src

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    import vrp_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl; logic [7:0] corr; logic [9:0] len; logic dir;
        logic [9:0] exp; logic ww;
    } vrp_row_t;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, veh_valid, veh_dir, freq_unreach, tel_valid, tel_wrong_way;
    logic [9:0] veh_atten_len, tel_length;
    logic hw_addr_wired = 1'b0, svc_ww_prefix, svc_dir_digit, pattern_set, err_led;
    logic [7:0] hw_addr_in = 8'h5A, bus_addr, loop_dist;
    logic chan_led, irq, prev;
    int n_fail = 0, n_checks = 0, cyc = 0, rises;
    vrp_row_t rows [7] = '{
        '{8'h13, 8'h0A, 10'h032, 1'b0, 10'h028, 1'b0}, '{8'h13, 8'h14, 10'h050, 1'b1, 10'h03C, 1'b1},
        '{8'h17, 8'h00, 10'h3FF, 1'b0, 10'h3FF, 1'b1}, '{8'h17, 8'h05, 10'h064, 1'b1, 10'h05F, 1'b0},
        '{8'h12, 8'h14, 10'h005, 1'b1, 10'h000, 1'b0}, '{8'h11, 8'h01, 10'h001, 1'b1, 10'h000, 1'b0},
        '{8'h16, 8'h00, 10'h007, 1'b0, 10'h007, 1'b0}};
    always #2 clk = ~clk;
    vrp_veh_src src (.clk(clk), .veh_valid(veh_valid), .veh_atten_len(veh_atten_len),
        .veh_dir(veh_dir), .freq_unreach(freq_unreach));
    vrp_top #(.LW(10), .HALF_CYC(4)) dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .veh_valid(veh_valid), .veh_atten_len(veh_atten_len), .veh_dir(veh_dir),
        .hw_addr_wired(hw_addr_wired), .hw_addr_in(hw_addr_in), .freq_unreach(freq_unreach),
        .tel_valid(tel_valid), .tel_length(tel_length), .tel_wrong_way(tel_wrong_way),
        .svc_ww_prefix(svc_ww_prefix), .svc_dir_digit(svc_dir_digit), .bus_addr(bus_addr),
        .loop_dist(loop_dist), .pattern_set(pattern_set), .err_led(err_led),
        .chan_led(chan_led), .irq(irq));
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held up to the rising edge at which waitrequest is seen low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;
        // Registered outputs settle one edge after the write lands
        repeat (2) @(negedge clk);
    endtask : bus
    task rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rchk
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(VRP_OFS_CTRL, 32'h13);
        rchk(VRP_OFS_LCORR, 32'h0A);
        rchk(VRP_OFS_ADDR, 32'h01);
        rchk(VRP_OFS_IRQ_MSK, 32'h0);
        $display("reset values done");
        foreach (rows[i]) begin
            bus(1'b1, VRP_OFS_CTRL, {24'h0, rows[i].ctrl});
            bus(1'b1, VRP_OFS_LCORR, {24'h0, rows[i].corr});
            src.send(rows[i].len, rows[i].dir);
            @(negedge clk);
            chk(tel_length, rows[i].exp);
            chk({tel_valid, tel_wrong_way}, {1'b1, rows[i].ww});
            chk({svc_ww_prefix, svc_dir_digit}, {rows[i].ww, rows[i].dir});
        end
        rchk(VRP_OFS_LAST, {20'h0, rows[6].ww, rows[6].dir, rows[6].exp});
        $display("vehicle rows done");
        bus(1'b1, VRP_OFS_LCORR, 32'h1F);
        rchk(VRP_OFS_LCORR, 32'h14);
        bus(1'b1, VRP_OFS_CTRL, 32'h3B);
        rchk(VRP_OFS_LCORR, {27'h0, VRP_LCORR_VAR});
        rchk(VRP_OFS_CTRL, 32'h1B);
        chk(pattern_set, 1'b1);
        bus(1'b1, VRP_OFS_LDIST, 32'h05);
        chk(loop_dist, VRP_LDIST_MIN);
        bus(1'b1, VRP_OFS_LDIST, 32'hFF);
        chk(loop_dist, VRP_LDIST_MAX);
        bus(1'b1, VRP_OFS_LDIST, 32'h50);
        chk(loop_dist, 8'h50);
        bus(1'b1, VRP_OFS_CTRL, 32'h13);
        chk({pattern_set, loop_dist}, {1'b0, VRP_LDIST_STD});
        bus(1'b1, VRP_OFS_DIAG, 32'h0);
        rchk(VRP_OFS_DIAG, {8'h0, VRP_LLEN_STD, 8'h01, VRP_LDIST_STD});
        rchk(5'h1D, 32'h0);
        bus(1'b1, VRP_OFS_ADDR, 32'h22);
        chk(bus_addr, 8'h22);
        @(posedge clk);
        hw_addr_wired <= 1'b1;
        rchk(VRP_OFS_DIAG, {8'h0, VRP_LLEN_STD, 8'h5A, VRP_LDIST_STD});
        chk(bus_addr, 8'h5A);
        $display("config tests done");
        bus(1'b1, VRP_OFS_IRQ_MSK, 32'h4);
        chk(irq, 1'b0);
        src.fault();
        rises = 0;
        prev = 1'b0;
        repeat (60) begin
            @(negedge clk);
            if (chan_led === 1'b1 && prev === 1'b0) rises++;
            prev = chan_led;
        end
        chk(rises, 3);
        chk({err_led, irq}, 2'b11);
        bus(1'b1, VRP_OFS_IRQ_ST, 32'h4);
        chk({err_led, irq}, 2'b00);
        rchk(VRP_OFS_IRQ_ST, 32'h3);
        $display("fault test done");
        tally_and_finish();
    end
endmodule : tb
